/* snp_pkg.sv */
//==========================================================================
// Functional notes
// - Serial write needs write enable latch set
// - Serial write frame end clears write enable
// - Exactly eight data bytes, else write dropped
// - Serial write bits arrive least significant first
// - Serial read bursts eight bytes, host ends
// - Read dummy clocks follow latency code bits
// - Read LSB first, no wrap past byte eight
// - Decode reset arm and reset opcodes
// - Deep sleep entered on opcode then select rise
// - Deep sleep ignores clock and data, outputs off
// - Wide select pulse wakes after exit delay
// - Deep sleep entry clears error registers
// - Write enable latch reads zero after deep sleep
// - Hibernate entered on opcode then select rise
// - Select fall starts hibernate wake with delay
// - Hibernate return reloads power-on defaults
// - Reset only when arm immediately precedes it
// - Any other command cancels armed reset
// - During reset only status read opcodes handed off, serial number reads still output data
//==========================================================================
package snp_pkg;

  //========================================================================
  // Opcodes
  localparam logic [7:0] OP_SN_WRITE      = 8'hC2;
  localparam logic [7:0] OP_SN_READ       = 8'hC3;
  localparam logic [7:0] OP_DEEP_SLEEP    = 8'hB9;
  localparam logic [7:0] OP_HIBERNATE     = 8'hBA;
  localparam logic [7:0] OP_RESET_ARM     = 8'h66;
  localparam logic [7:0] OP_RESET        = 8'h99;
  localparam logic [7:0] OP_ANY_REG_READ  = 8'h65;
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_STATUS1_READ  = 8'h05;

  //========================================================================
  // Serial number layout
  localparam int unsigned SN_BYTES = 8;
  localparam int unsigned SN_BYTE_W = 8;
  localparam logic [6:0]  SN_BITS  = 7'h40;

  //========================================================================
  // Read latency, dummy clocks per latency code
  localparam logic [6:0] DUMMY_LC0 = 7'h00;
  localparam logic [6:0] DUMMY_LC1 = 7'h02;
  localparam logic [6:0] DUMMY_LC2 = 7'h04;
  localparam logic [6:0] DUMMY_LC3 = 7'h08;

  //========================================================================
  // Timing, in ns, and derived clock counts
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned SLEEP_PULSE_NS   = 200;     // Least select low width
  localparam int unsigned SLEEP_EXIT_NS    = 3000;    // Deep sleep exit delay
  localparam int unsigned HIB_EXIT_NS      = 450000;  // Hibernate exit delay
  localparam int unsigned SOFT_RESET_NS    = 1000;    // Soft reset delay
  localparam int unsigned SLEEP_PULSE_CYC  = (SLEEP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SLEEP_EXIT_CYC   = (SLEEP_EXIT_NS / CLK_PERIOD_NS > 0) ? SLEEP_EXIT_NS / CLK_PERIOD_NS : 1;
  localparam int unsigned HIB_EXIT_CYC     = (HIB_EXIT_NS / CLK_PERIOD_NS > 0) ? HIB_EXIT_NS / CLK_PERIOD_NS : 1;
  localparam int unsigned SOFT_RESET_CYC   = (SOFT_RESET_NS / CLK_PERIOD_NS > 0) ? SOFT_RESET_NS / CLK_PERIOD_NS : 1;
  localparam int unsigned TIMER_W          = 24;
  typedef logic [TIMER_W-1:0] snp_timer_t;

  //========================================================================
  // Types
  typedef enum logic [3:0] {
    RES_NONE, RES_WRITE_ENABLE_CMD, RES_SNW_OK, RES_SNW_BAD, RES_DEEP, RES_HIB, RES_ARM, RES_RST, RES_OTHER
  } snp_res_e;

  typedef enum logic [2:0] {
    PH_OPCODE, PH_DUMMY, PH_WDATA, PH_RDATA, PH_TAIL
  } snp_phase_e;

  typedef enum logic [2:0] {
    ST_ACTIVE, ST_DEEP, ST_DEEP_WAKE, ST_HIB, ST_HIB_WAKE, ST_SRST
  } snp_pwr_e;

  // Configuration carried into the link domain
  typedef struct packed {
    logic       quad;
    logic       dual;
    logic [1:0] latency;
  } snp_link_cfg_s;

  // Power state carried into the link domain
  typedef struct packed {
    logic blocked;
    logic busy;
  } snp_link_stat_s;

endpackage

/* snp_sn_store.sv */
`timescale 1ns/1ps
`default_nettype none
//==========================================================================
// Serial number storage, byte array, no reset so content persists
module snp_sn_store #(
  parameter int unsigned BYTES  = snp_pkg::SN_BYTES,
  parameter int unsigned BYTE_W = snp_pkg::SN_BYTE_W
) (
  // Clock
  input  wire logic                      clk,
  // Write port, whole word at once
  input  wire logic                      we,
  input  wire logic [BYTES*BYTE_W-1:0]   wdata,
  // Registered read data
  output logic      [BYTES*BYTE_W-1:0]   rdata
);

  //========================================================================
  // Storage array, one entry per byte
  logic [BYTE_W-1:0] mem [BYTES];

  genvar gi;
  generate
    for (gi = 0; gi < BYTES; gi++) begin : g_byte
      // Byte cell, untouched by any reset
      always_ff @(posedge clk) begin
        if (we) begin
          mem[gi] <= wdata[gi*BYTE_W +: BYTE_W];
        end
      end
      // Read register per byte
      always_ff @(posedge clk) begin
        rdata[gi*BYTE_W +: BYTE_W] <= mem[gi];
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* snp_cmd.sv */
`timescale 1ns/1ps
`default_nettype none
//==========================================================================
// Serial number, power mode and soft reset command logic
module snp_cmd #(
  parameter int unsigned PULSE_CYC      = snp_pkg::SLEEP_PULSE_CYC,
  parameter int unsigned SLEEP_EXIT_CYC = snp_pkg::SLEEP_EXIT_CYC,
  parameter int unsigned HIB_EXIT_CYC   = snp_pkg::HIB_EXIT_CYC,
  parameter int unsigned SRST_CYC       = snp_pkg::SOFT_RESET_CYC
) (
  // System clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Link pins
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic [3:0] io_in,
  output logic      [3:0] io_out,
  output logic      [3:0] io_oe,
  // Configuration from the rest of the device
  input  wire logic       dual_io_mode,
  input  wire logic       quad_io_mode,
  input  wire logic       latency_code_bit0,
  input  wire logic       latency_code_bit1,
  // Opcode hand-off, link clock domain
  output logic      [7:0] frame_opcode,
  output logic            frame_opcode_valid,
  // Device state, system clock domain
  output logic            write_enable_latch,
  output logic            deep_sleep,
  output logic            hibernate_active,
  output logic            soft_reset_busy,
  output logic            error_regs_clear,
  output logic            defaults_reload,
  output logic            soft_reset_pulse
);

  //========================================================================
  // Link domain declarations
  logic                    frame_rst_n;   // Frame reset, select high or reset
  snp_pkg::snp_link_cfg_s  cfg_s1;        // Config sync stage one
  snp_pkg::snp_link_cfg_s  cfg_s2;        // Config sync stage two
  snp_pkg::snp_link_stat_s st_s1;         // Status sync stage one
  snp_pkg::snp_link_stat_s st_s2;         // Status sync stage two
  snp_pkg::snp_phase_e     phase;         // Frame phase
  logic [6:0]              cnt;           // Clock or bit count in phase
  logic [7:0]              op;            // Opcode shifter
  logic [7:0]              next_op;       // Opcode after this edge
  logic [2:0]              lane_w;        // Bits per clock
  logic [6:0]              op_last;       // Last opcode clock index
  logic [6:0]              dummy_clks;    // Dummy clocks for a read
  logic [63:0]             sn_shift;      // Incoming serial number
  snp_pkg::snp_res_e       res;           // Frame outcome
  snp_pkg::snp_res_e       op_res;        // Outcome from opcode alone
  logic                    frame_tog;     // Toggles once per clocked frame
  logic                    rd_started;    // Read data already under way
  logic [63:0]             rd_shift;      // Outgoing bits
  logic [63:0]             rd_src;        // Word to take bits from
  logic [63:0]             sn_rdata;      // Stored serial number
  logic                    blk_seen;      // Sleep seen during this frame

  //========================================================================
  // System domain declarations
  logic                    cs_s1;         // Select sync stage one
  logic                    cs_s2;         // Select sync stage two
  logic                    cs_d;          // Select delayed for edges
  logic                    tog_s1;        // Frame toggle sync one
  logic                    tog_s2;        // Frame toggle sync two
  logic                    tog_seen;      // Last frame toggle handled
  logic                    frame_ok;      // Frame began while active
  snp_pkg::snp_res_e       res_s1;        // Outcome sync one
  snp_pkg::snp_res_e       res_s2;        // Outcome sync two
  snp_pkg::snp_pwr_e       state;         // Power state
  snp_pkg::snp_timer_t     timer;         // Delay counter
  logic                    armed;         // Reset armed
  logic                    sn_we;         // Serial number store strobe
  logic                    cs_rise;       // Select rose
  logic                    cs_fall;       // Select fell
  logic                    act;           // Completed frame to act on
  logic                    enter_deep;    // Deep sleep entry
  logic                    enter_hib;     // Hibernate entry
  logic                    start_srst;    // Soft reset start
  logic                    hib_done;      // Hibernate wake complete
  logic                    deep_done;     // Deep sleep wake complete

  //========================================================================
  // Helpers
  function automatic logic [2:0] lanes(input snp_pkg::snp_link_cfg_s c);
    if (c.quad) begin
      return 3'h4;
    end else if (c.dual) begin
      return 3'h2;
    end
    return 3'h1;
  endfunction

  // Decode a full opcode into its outcome
  function automatic snp_pkg::snp_res_e decode(input logic [7:0] o);
    unique case (o)
      snp_pkg::OP_WRITE_ENABLE: return snp_pkg::RES_WRITE_ENABLE_CMD;
      snp_pkg::OP_SN_WRITE:     return snp_pkg::RES_SNW_BAD;
      snp_pkg::OP_DEEP_SLEEP:   return snp_pkg::RES_DEEP;
      snp_pkg::OP_HIBERNATE:    return snp_pkg::RES_HIB;
      snp_pkg::OP_RESET_ARM:    return snp_pkg::RES_ARM;
      snp_pkg::OP_RESET:        return snp_pkg::RES_RST;
      default:                  return snp_pkg::RES_OTHER;
    endcase
  endfunction

  //========================================================================
  // Link domain
  assign frame_rst_n = rstn & ~cs_n;
  assign lane_w      = lanes(cfg_s2);
  assign op_res      = decode(next_op);
  assign rd_src      = rd_started ? rd_shift : sn_rdata;

  // Opcode width per lane count
  always_comb begin
    unique case (lane_w)
      3'h4:    op_last = 7'h01;
      3'h2:    op_last = 7'h03;
      default: op_last = 7'h07;
    endcase
  end

  // Dummy clocks from latency code
  always_comb begin
    unique case (cfg_s2.latency)
      2'h0: dummy_clks = snp_pkg::DUMMY_LC0;
      2'h1: dummy_clks = snp_pkg::DUMMY_LC1;
      2'h2: dummy_clks = snp_pkg::DUMMY_LC2;
      2'h3: dummy_clks = snp_pkg::DUMMY_LC3;
    endcase
  end

  // Opcode arrives most significant bit first, io0 lowest
  always_comb begin
    unique case (lane_w)
      3'h4:    next_op = {op[3:0], io_in[3:0]};
      3'h2:    next_op = {op[5:0], io_in[1:0]};
      default: next_op = {op[6:0], io_in[0]};
    endcase
  end

  // Configuration and status synchronisers on the link clock
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      cfg_s1 <= '0;
      cfg_s2 <= '0;
      st_s1  <= '0;
      st_s2  <= '0;
    end else begin
      cfg_s1 <= '{quad: quad_io_mode, dual: dual_io_mode,
                  latency: {latency_code_bit1, latency_code_bit0}};
      cfg_s2 <= cfg_s1;
      st_s1  <= snp_pkg::snp_link_stat_s'({deep_sleep | hibernate_active, soft_reset_busy});
      st_s2  <= st_s1;
    end
  end

  // Sleep seen in a frame keeps that whole frame ignored, even once awake
  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      blk_seen <= 1'b0;
    end else if (st_s2.blocked) begin
      blk_seen <= 1'b1;
    end
  end

  // Frame sequencer, cleared whenever select is high
  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      phase <= snp_pkg::PH_OPCODE;
      cnt   <= '0;
      op    <= '0;
    end else begin
      unique case (phase)
        // Shift in the opcode
        snp_pkg::PH_OPCODE: begin
          op  <= next_op;
          cnt <= cnt + 7'h01;
          if (cnt == op_last) begin
            cnt <= '0;
            if (next_op == snp_pkg::OP_SN_READ) begin
              phase <= (dummy_clks == '0) ? snp_pkg::PH_RDATA : snp_pkg::PH_DUMMY;
            end else if (next_op == snp_pkg::OP_SN_WRITE) begin
              phase <= snp_pkg::PH_WDATA;
            end else begin
              phase <= snp_pkg::PH_TAIL;
            end
          end
        end
        // Latency clocks before read data
        snp_pkg::PH_DUMMY: begin
          cnt <= cnt + 7'h01;
          if (cnt == dummy_clks - 7'h01) begin
            cnt   <= '0;
            phase <= snp_pkg::PH_RDATA;
          end
        end
        // Count data bits, saturating past a full number
        snp_pkg::PH_WDATA: begin
          if (cnt <= snp_pkg::SN_BITS) begin
            cnt <= cnt + 7'(lane_w);
          end
        end
        // Read data and trailing clocks hold their phase
        snp_pkg::PH_RDATA, snp_pkg::PH_TAIL: begin
          cnt <= cnt;
        end
      endcase
    end
  end

  // Opcode hand-off to the rest of the device
  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      frame_opcode       <= '0;
      frame_opcode_valid <= 1'b0;
    end else if (phase == snp_pkg::PH_OPCODE && cnt == op_last) begin
      frame_opcode       <= next_op;
      frame_opcode_valid <= ~(st_s2.blocked | blk_seen) & (~st_s2.busy
                            | next_op == snp_pkg::OP_STATUS1_READ
                            | next_op == snp_pkg::OP_ANY_REG_READ);
    end
  end

  // Serial number data shifter, least significant bit first, kept past frame end
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      sn_shift <= '0;
    end else if (phase == snp_pkg::PH_WDATA && cnt < snp_pkg::SN_BITS) begin
      unique case (lane_w)
        3'h4:    sn_shift <= {io_in[3:0], sn_shift[63:4]};
        3'h2:    sn_shift <= {io_in[1:0], sn_shift[63:2]};
        default: sn_shift <= {io_in[0], sn_shift[63:1]};
      endcase
    end
  end

  // Frame outcome and per-frame toggle, survive select high
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      res       <= snp_pkg::RES_NONE;
      frame_tog <= 1'b0;
    end else if (phase == snp_pkg::PH_OPCODE && cnt == '0) begin
      res       <= snp_pkg::RES_NONE;
      frame_tog <= ~frame_tog;
    end else if (phase == snp_pkg::PH_OPCODE && cnt == op_last) begin
      res <= op_res;
    end else if (phase == snp_pkg::PH_WDATA) begin
      res <= (cnt + 7'(lane_w) == snp_pkg::SN_BITS) ? snp_pkg::RES_SNW_OK : snp_pkg::RES_SNW_BAD;
    end else if (phase == snp_pkg::PH_TAIL) begin
      res <= snp_pkg::RES_OTHER;
    end
  end

  // Read data driven on the falling edge, lanes by mode
  always_ff @(negedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      rd_started <= 1'b0;
      rd_shift   <= '0;
      io_out     <= '0;
      io_oe      <= '0;
    end else if (phase == snp_pkg::PH_RDATA && !(st_s2.blocked || blk_seen)) begin
      rd_started <= 1'b1;
      unique case (lane_w)
        3'h4: begin
          io_out   <= rd_src[3:0];
          io_oe    <= 4'hF;
          rd_shift <= {4'h0, rd_src[63:4]};
        end
        3'h2: begin
          io_out   <= {2'h0, rd_src[1:0]};
          io_oe    <= 4'h3;
          rd_shift <= {2'h0, rd_src[63:2]};
        end
        default: begin
          io_out   <= {2'h0, rd_src[0], 1'b0};
          io_oe    <= 4'h2;
          rd_shift <= {1'b0, rd_src[63:1]};
        end
      endcase
    end else begin
      io_out <= '0;
      io_oe  <= '0;
    end
  end

  //========================================================================
  // System domain
  assign cs_rise    = cs_s2 & ~cs_d;
  assign cs_fall    = ~cs_s2 & cs_d;
  assign act        = cs_rise & (tog_s2 != tog_seen) & frame_ok & (state == snp_pkg::ST_ACTIVE);
  assign enter_deep = act & (res_s2 == snp_pkg::RES_DEEP);
  assign enter_hib  = act & (res_s2 == snp_pkg::RES_HIB);
  assign start_srst = act & (res_s2 == snp_pkg::RES_RST) & armed;
  assign deep_done  = (state == snp_pkg::ST_DEEP_WAKE) & (timer == snp_pkg::snp_timer_t'(SLEEP_EXIT_CYC - 1));
  assign hib_done   = (state == snp_pkg::ST_HIB_WAKE) & (timer == snp_pkg::snp_timer_t'(HIB_EXIT_CYC - 1));

  // Select, frame toggle and outcome synchronisers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cs_s1    <= 1'b1;
      cs_s2    <= 1'b1;
      cs_d     <= 1'b1;
      tog_s1   <= 1'b0;
      tog_s2   <= 1'b0;
      res_s1   <= snp_pkg::RES_NONE;
      res_s2   <= snp_pkg::RES_NONE;
    end else begin
      cs_s1    <= cs_n;
      cs_s2    <= cs_s1;
      cs_d     <= cs_s2;
      tog_s1   <= frame_tog;
      tog_s2   <= tog_s1;
      res_s1   <= res;
      res_s2   <= res_s1;
    end
  end

  // Frame bookkeeping, a frame counts only if it began while active
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tog_seen <= 1'b0;
      frame_ok <= 1'b0;
    end else begin
      if (cs_fall) begin
        frame_ok <= (state == snp_pkg::ST_ACTIVE);
      end
      if (cs_rise) begin
        tog_seen <= tog_s2;
      end
    end
  end

  // Power state and delay timer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= snp_pkg::ST_ACTIVE;
      timer <= '0;
    end else begin
      unique case (state)
        // Normal operation
        snp_pkg::ST_ACTIVE: begin
          timer <= '0;
          if (enter_deep) begin
            state <= snp_pkg::ST_DEEP;
          end else if (enter_hib) begin
            state <= snp_pkg::ST_HIB;
          end else if (start_srst) begin
            state <= snp_pkg::ST_SRST;
          end
        end
        // Measure select low width
        snp_pkg::ST_DEEP: begin
          if (cs_s2) begin
            timer <= '0;
          end else if (timer == snp_pkg::snp_timer_t'(PULSE_CYC - 1)) begin
            timer <= '0;
            state <= snp_pkg::ST_DEEP_WAKE;
          end else begin
            timer <= timer + snp_pkg::snp_timer_t'(1);
          end
        end
        // Deep sleep exit delay
        snp_pkg::ST_DEEP_WAKE: begin
          timer <= timer + snp_pkg::snp_timer_t'(1);
          if (deep_done) begin
            state <= snp_pkg::ST_ACTIVE;
          end
        end
        // Wait for select to fall
        snp_pkg::ST_HIB: begin
          timer <= '0;
          if (cs_fall) begin
            state <= snp_pkg::ST_HIB_WAKE;
          end
        end
        // Hibernate exit delay
        snp_pkg::ST_HIB_WAKE: begin
          timer <= timer + snp_pkg::snp_timer_t'(1);
          if (hib_done) begin
            state <= snp_pkg::ST_ACTIVE;
          end
        end
        // Soft reset delay
        snp_pkg::ST_SRST: begin
          timer <= timer + snp_pkg::snp_timer_t'(1);
          if (timer == snp_pkg::snp_timer_t'(SRST_CYC - 1)) begin
            state <= snp_pkg::ST_ACTIVE;
          end
        end
      endcase
    end
  end

  // Write enable latch
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      write_enable_latch <= 1'b0;
    end else if (enter_deep | hib_done | start_srst) begin
      write_enable_latch <= 1'b0;
    end else if (act & (res_s2 == snp_pkg::RES_SNW_OK | res_s2 == snp_pkg::RES_SNW_BAD)) begin
      write_enable_latch <= 1'b0;
    end else if (act & (res_s2 == snp_pkg::RES_WRITE_ENABLE_CMD)) begin
      write_enable_latch <= 1'b1;
    end
  end

  // Reset arm, any other complete command cancels it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      armed <= 1'b0;
    end else if (enter_deep | enter_hib | hib_done) begin
      armed <= 1'b0;
    end else if (act & (res_s2 != snp_pkg::RES_NONE)) begin
      armed <= (res_s2 == snp_pkg::RES_ARM);
    end
  end

  // Serial number commit strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sn_we <= 1'b0;
    end else begin
      sn_we <= act & (res_s2 == snp_pkg::RES_SNW_OK) & write_enable_latch;
    end
  end

  // Status flags and event pulses
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      deep_sleep       <= 1'b0;
      hibernate_active <= 1'b0;
      soft_reset_busy  <= 1'b0;
      error_regs_clear <= 1'b0;
      defaults_reload  <= 1'b0;
      soft_reset_pulse <= 1'b0;
    end else begin
      deep_sleep       <= (state == snp_pkg::ST_DEEP) | (state == snp_pkg::ST_DEEP_WAKE);
      hibernate_active <= (state == snp_pkg::ST_HIB) | (state == snp_pkg::ST_HIB_WAKE);
      soft_reset_busy  <= (state == snp_pkg::ST_SRST);
      error_regs_clear <= enter_deep | start_srst;
      defaults_reload  <= hib_done;
      soft_reset_pulse <= start_srst;
    end
  end

  //========================================================================
  // Serial number storage
  snp_sn_store #(
    .BYTES  (snp_pkg::SN_BYTES),
    .BYTE_W (snp_pkg::SN_BYTE_W)
  ) u_store (
    .clk   (clk),
    .we    (sn_we),
    .wdata (sn_shift),
    .rdata (sn_rdata)
  );

endmodule
`default_nettype wire

/* snp_cmd_properties.sv */
`timescale 1ns/1ps
`default_nettype none
//==========
// Port timing checks for the command block
module snp_cmd_properties (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // Link side
  input wire logic       cs_n,
  input wire logic [3:0] io_oe,
  // Device state
  input wire logic       write_enable_latch,
  input wire logic       deep_sleep,
  input wire logic       hibernate_active,
  input wire logic       soft_reset_busy,
  input wire logic       error_regs_clear,
  input wire logic       defaults_reload,
  input wire logic       soft_reset_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wel_sleep_a: assert property (deep_sleep && $past(deep_sleep) |-> !write_enable_latch)
    else $error("latch set in deep sleep");
  oe_asleep_a: assert property ((deep_sleep || hibernate_active) |-> io_oe == 4'h0)
    else $error("output enabled while asleep");
  oe_idle_a: assert property (cs_n && $past(cs_n) |-> io_oe == 4'h0)
    else $error("output enabled between frames");
  clear_cause_a: assert property (error_regs_clear |-> ##[0:2] (deep_sleep || soft_reset_busy))
    else $error("clear without sleep or reset");
  clear_once_a: assert property (error_regs_clear |=> !error_regs_clear)
    else $error("clear pulse too long");
  srst_busy_a: assert property (soft_reset_pulse |-> ##[0:2] soft_reset_busy)
    else $error("reset start without busy");
  busy_hold_a: assert property ($rose(soft_reset_busy) |-> soft_reset_busy[*4])
    else $error("reset busy too short");
  reload_end_a: assert property (defaults_reload |-> ##[0:1] !hibernate_active)
    else $error("reload while still hibernating");
  modes_excl_a: assert property (!(deep_sleep && hibernate_active))
    else $error("both sleep modes at once");
  wel_busy_a: assert property (soft_reset_busy && $past(soft_reset_busy) |-> !write_enable_latch)
    else $error("latch set during reset");
endmodule
`default_nettype wire

/* snp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
//==========
// Link host: mode 0, clock stands low outside frames
module snp_host_model (
  // Link pins
  output logic       sck,
  output logic       cs_n,
  output logic [3:0] io_in,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe
);
  logic [71:0] rx; // Bits seen while the device drives
  int          k;  // Count of captured bits
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    io_in = 4'h0;
  end
  // Opcode MSB first, then n bits of data LSB first
  task automatic frame(input logic [7:0] op, input int n, input logic [63:0] d);
    #3 rx = 72'h0;
    k = 0;
    cs_n = 1'b0;
    for (int i = 0; i < 8 + n; i++) begin
      io_in[0] = (i < 8) ? op[7-i] : d[(i-8)%64];
      #62.5 sck = 1'b1;
      if (io_oe[1] === 1'b1 && k < 72) begin
        rx[k] = io_out[1];
        k++;
      end
      #62.5 sck = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    io_in = ~io_in; // Released line shows inverse
  endtask
endmodule
`default_nettype wire

/* tb_serial_number_power_reset_cmds.sv */
`timescale 1ns/1ps
`default_nettype none
//==========
// Row bench: frame in, device state and read bits out
module tb_serial_number_power_reset_cmds;
  typedef struct packed {logic [7:0] op; logic [7:0] n; logic [1:0] lc; logic rd; logic [3:0] e;} snp_row_s;
  localparam logic [63:0] SN_A = 64'h0123_4567_89AB_CDEF;
  localparam logic [63:0] SN_B = 64'hFEDC_BA98_7654_3210;
  logic clk = 1'b0, rstn, latency_code_bit0 = 1'b0, latency_code_bit1 = 1'b0;
  logic dual_io_mode = 1'b0, quad_io_mode = 1'b0, sck, cs_n, frame_opcode_valid;
  logic [3:0] io_in, io_out, io_oe;
  logic [7:0] frame_opcode;
  logic [8:0] last_op; // Opcode hand-off seen at the last link fall
  logic write_enable_latch, deep_sleep, hibernate_active, soft_reset_busy;
  logic error_regs_clear, defaults_reload, soft_reset_pulse;
  int fails = 0, n_tests = 0;
  wire [71:0] st = {68'h0, write_enable_latch, deep_sleep, hibernate_active, soft_reset_busy};
  // Expected state: latch, deep sleep, hibernate, reset busy
  snp_row_s rows [20] = '{'{8'h06, 8'h00, 2'h0, 1'b0, 4'h8}, '{8'hC2, 8'h40, 2'h0, 1'b1, 4'h0},
    '{8'hC2, 8'h40, 2'h0, 1'b0, 4'h0}, '{8'h06, 8'h00, 2'h0, 1'b0, 4'h8}, '{8'hC2, 8'h38, 2'h0, 1'b0, 4'h0},
    '{8'hC3, 8'h48, 2'h0, 1'b1, 4'h0}, '{8'hC3, 8'h4A, 2'h1, 1'b1, 4'h0}, '{8'hC3, 8'h4C, 2'h2, 1'b1, 4'h0},
    '{8'hC3, 8'h50, 2'h3, 1'b1, 4'h0}, '{8'h06, 8'h00, 2'h0, 1'b0, 4'h8}, '{8'hB9, 8'h00, 2'h0, 1'b0, 4'h4},
    '{8'hC3, 8'h48, 2'h0, 1'b0, 4'h0}, '{8'hB9, 8'h08, 2'h0, 1'b0, 4'h0}, '{8'hBA, 8'h00, 2'h0, 1'b0, 4'h2},
    '{8'hC3, 8'h48, 2'h0, 1'b0, 4'h0}, '{8'h66, 8'h00, 2'h0, 1'b0, 4'h0}, '{8'h99, 8'h00, 2'h0, 1'b0, 4'h1},
    '{8'h66, 8'h00, 2'h0, 1'b0, 4'h0}, '{8'h06, 8'h00, 2'h0, 1'b0, 4'h8}, '{8'h99, 8'h00, 2'h0, 1'b0, 4'h8}};
  snp_cmd #(.PULSE_CYC(2), .SLEEP_EXIT_CYC(5), .HIB_EXIT_CYC(10), .SRST_CYC(5)) i_dut (.*);
  snp_host_model i_host (.sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
  always #5 clk = ~clk;
  always @(negedge sck) last_op <= {frame_opcode_valid, frame_opcode};
  // Compare and count
  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard
  initial begin
    #900us fails++;
    end_of_test();
  end
  //==========
  // Rows, then a reset in mid-run
  initial begin
    rstn = 1'b0; // Falling edge fires every asynchronous reset
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    check(st, 72'h0); // Idle after reset
    for (int i = 0; i < 20; i++) begin
      {latency_code_bit1, latency_code_bit0} = rows[i].lc;
      i_host.frame(rows[i].op, rows[i].n, rows[i].rd ? SN_A : SN_B);
      repeat (7) @(negedge clk);
      check(st, {68'h0, rows[i].e});
      check(i_host.rx, (rows[i].op == 8'hC3 && rows[i].rd) ? {8'h00, SN_A} : 72'h0);
      check({63'h0, last_op}, {63'h0, rows[i].op != 8'hC3 || rows[i].rd, rows[i].op});
      $display("row %0d done", i);
      repeat (40) @(negedge clk);
    end
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    check(st, 72'h0); // Reset clears the latch
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    i_host.frame(8'hC3, 72, SN_B);
    check(i_host.rx, {8'h00, SN_A});
    $display("reset test done");
    end_of_test();
  end
endmodule
bind snp_cmd snp_cmd_properties i_props (.*);
`default_nettype wire
